//--- pmt_pkg.sv
// Package for the power-mode and command-timing link between a DRAM-like
// device end and its controller end; assumes a 250 MHz system clock.
// Functional notes
// - Link-on low in standby enters shutdown
// - Standby and shutdown nest inside self-refresh
// - Self-refresh runs own oscillator and refresh
// - No commands during self-refresh except mode changes
// - Open to close same bank: 60 ns
// - Open to open same bank: 88 ns
// - Refresh to refresh: 88 ns
// - Precharge period before dependent command: 28 ns
// - Open to open other bank: 10 ns
// - Write recovery: 2 ticks plus 10 ns
// - Self-refresh exit to open: 88 ns; a listen wake after exit cuts this to the 10 ns wake hold-off
// - Page read max 32, bank read max 64 ticks
// - Page write min 17, bank write min 30 ns
// - Read to write turnaround: 5 ns
// - Write to read: 2 ticks plus 20 ns
// - Listen reasserted to next command: 10 ns
// - Control write to next command: 10 ns
// - Vernier change reaches outputs within 10 ns
// - Timing values readable as parameter registers
// - Listen low outside packets enters standby
// - Shutdown stops clocks, keeps only link-on receiver
package pmt_pkg;
  // ----------------------------------------
  // Timing figures (ns, ticks) and clock
  // ----------------------------------------
  localparam int CLK_PS = 4000;
  localparam int TICK_CYC = 2;
  localparam int OPEN_TO_CLOSE_MIN_NS = 60;
  localparam int OPEN_TO_OPEN_SAME_BANK_MIN_NS = 88;
  localparam int REFRESH_TO_REFRESH_MIN_NS = 88;
  localparam int PRECHARGE_PERIOD_MIN_NS = 28;
  localparam int OPEN_TO_OPEN_OTHER_BANK_MIN_NS = 10;
  localparam int WRITE_RECOVERY_FIFO_PART_TK = 2;
  localparam int WRITE_RECOVERY_INTERNAL_PART_NS = 10;
  localparam int SELF_REFRESH_EXIT_TO_OPEN_MIN_NS = 88;
  localparam int PAGE_READ_DELAY_MAX_TK = 32;
  localparam int BANK_READ_DELAY_MAX_TK = 64;
  localparam int PAGE_WRITE_DELAY_MIN_NS = 17;
  localparam int BANK_WRITE_DELAY_MIN_NS = 30;
  localparam int READ_TO_WRITE_TURNAROUND_MIN_NS = 5;
  localparam int WRITE_TO_READ_FIFO_PART_TK = 2;
  localparam int WRITE_TO_READ_BALANCE_PART_NS = 20;
  localparam int WAKE_TO_NEXT_COMMAND_MIN_NS = 10;
  localparam int CTRL_WRITE_TO_NEXT_COMMAND_MIN_NS = 10;
  localparam int VERNIER_TO_OUTPUT_DELAY_NS = 10;
  // Least times round up, longest round down
  localparam int C_OPEN_CLOSE = (OPEN_TO_CLOSE_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_OPEN_SAME = (OPEN_TO_OPEN_SAME_BANK_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_REF_REF = (REFRESH_TO_REFRESH_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_PRE = (PRECHARGE_PERIOD_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_OPEN_OTHER = (OPEN_TO_OPEN_OTHER_BANK_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_WR_REC = WRITE_RECOVERY_FIFO_PART_TK * TICK_CYC
    + (WRITE_RECOVERY_INTERNAL_PART_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_XSR = (SELF_REFRESH_EXIT_TO_OPEN_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_RD_WR = (READ_TO_WRITE_TURNAROUND_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_WR_RD = WRITE_TO_READ_FIFO_PART_TK * TICK_CYC
    + (WRITE_TO_READ_BALANCE_PART_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_WAKE = (WAKE_TO_NEXT_COMMAND_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_CTRL = (CTRL_WRITE_TO_NEXT_COMMAND_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_VERN = (VERNIER_TO_OUTPUT_DELAY_NS * 1000) / CLK_PS;
  localparam int SELF_REFRESH_PERIOD_CYC = 1953;
  // ----------------------------------------
  // Commands and device modes
  // ----------------------------------------
  typedef enum logic [3:0] {
    PMT_CMD_NOP = 4'h0, PMT_CMD_OPEN = 4'h1, PMT_CMD_CLOSE = 4'h2, PMT_CMD_READ = 4'h3,
    PMT_CMD_WRITE = 4'h4, PMT_CMD_REFRESH = 4'h5, PMT_CMD_CTRL_WR = 4'h6,
    PMT_CMD_VERNIER = 4'h7, PMT_CMD_SR_ENTER = 4'h8, PMT_CMD_SR_EXIT = 4'h9,
    PMT_CMD_TREG_RD = 4'hA
  } pmt_cmd_e;
  typedef enum logic [2:0] {
    PMT_ACTIVE = 3'b001, PMT_STANDBY = 3'b010, PMT_SHUTDOWN = 3'b100
  } pmt_mode_e;
  localparam int TREG_COUNT = 8;
endpackage

//--- pmt_link_if.sv
// Link between controller end and device end: command word, strobe, the
// listen and link-on levels and a shared two-way data pin set with enables.
// Assumes both ends run off their own copies of the system clock.
`timescale 1ns/1ps
`default_nettype none
interface pmt_link_if;
  import pmt_pkg::*;
  logic link_clk;
  logic listen;
  logic link_on;
  logic cmd_vld;
  pmt_cmd_e cmd;
  logic [2:0] bank;
  logic [15:0] cmd_arg;
  logic [15:0] dq_ctl_o;
  logic dq_ctl_oe_n;
  logic [15:0] dq_dev_o;
  logic dq_dev_oe_n;
  logic [15:0] dq;
  // Resolved data wire; the controller wins on a clash
  assign dq = !dq_ctl_oe_n ? dq_ctl_o : (!dq_dev_oe_n ? dq_dev_o : 16'h0000);
  modport ctl (output link_clk, output listen, output link_on, output cmd_vld, output cmd,
    output bank, output cmd_arg, output dq_ctl_o, output dq_ctl_oe_n, input dq);
  modport dev (input link_clk, input listen, input link_on, input cmd_vld, input cmd,
    input bank, input cmd_arg, output dq_dev_o, output dq_dev_oe_n, input dq);
endinterface
`default_nettype wire

//--- pmt_gap_timer.sv
// Reloadable down-counter: done once the loaded spacing has elapsed.
// Assumes same-clock inputs.
`timescale 1ns/1ps
`default_nettype none
module pmt_gap_timer
#(
  parameter int W = 8
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  typedef struct packed { logic [W-1:0] cnt; } pmt_gt_s;
  pmt_gt_s st_r;
  pmt_gt_s st_nxt;
  // Next count
  always_comb
  begin
    st_nxt = st_r;
    if (load)
      st_nxt.cnt = count;
    else if (st_r.cnt != '0)
      st_nxt.cnt = st_r.cnt - 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign done = (st_r.cnt == '0);
endmodule
`default_nettype wire

//--- pmt_ctl_end.sv
// Controller end: accepts user commands, keeps every spacing but self-refresh exit, which a listen wake cuts to the wake hold-off,
// drives the link clock by division and the listen and link-on levels.
// Assumes the device end is joined over pmt_link_if.ctl.
`timescale 1ns/1ps
`default_nettype none
module pmt_ctl_end
  import pmt_pkg::*;
#(
  parameter int NBANK = 8,
  parameter int TW = 8
)
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  pmt_link_if.ctl LINK,
  input wire logic REQ_VLD,
  output logic REQ_RDY,
  input wire logic [3:0] REQ_CMD,
  input wire logic [2:0] REQ_BANK,
  input wire logic [15:0] REQ_ARG,
  input wire logic [15:0] REQ_WDATA,
  input wire logic WANT_LISTEN,
  input wire logic WANT_LINK_ON,
  output logic [15:0] RD_DATA,
  output logic BANKS_CLOSED
);
  typedef struct packed {
    logic div;
    logic listen;
    logic link_on;
    logic in_sr;
    logic cmd_vld;
    logic [3:0] cmd;
    logic [2:0] bank;
    logic [15:0] arg;
    logic [15:0] wd;
    logic wd_oe_n;
    logic [NBANK-1:0] open;
    logic [15:0] rd;
    logic [1:0] trd;
  } pmt_ctl_s;
  pmt_ctl_s st_r;
  pmt_ctl_s st_nxt;
  logic [NBANK-1:0] same_done;
  logic [NBANK-1:0] pre_done;
  logic [NBANK-1:0] oc_done;
  logic [NBANK-1:0] rec_done;
  logic g_open_ok, g_ref_ok, g_rw_ok, g_wr_ok, g_cmd_ok;
  logic ld_other, ld_ref, ld_rw, ld_wr, ld_cmd;
  logic [TW-1:0] cmd_gap;
  logic take;
  pmt_cmd_e rc;
  logic ok;
  // ----------------------------------------
  // Per-bank spacing timers
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < NBANK; b++)
    begin : g_bank
      logic hit;
      assign hit = take && (REQ_BANK == 3'(b));
      pmt_gap_timer #(.W(TW)) u_same (.clk(CLK_SYS), .srst(SRST),
        .load(hit && rc == PMT_CMD_OPEN), .count(TW'(C_OPEN_SAME)), .done(same_done[b]));
      pmt_gap_timer #(.W(TW)) u_oc (.clk(CLK_SYS), .srst(SRST),
        .load(hit && rc == PMT_CMD_OPEN), .count(TW'(C_OPEN_CLOSE)), .done(oc_done[b]));
      pmt_gap_timer #(.W(TW)) u_pre (.clk(CLK_SYS), .srst(SRST),
        .load(hit && rc == PMT_CMD_CLOSE), .count(TW'(C_PRE)), .done(pre_done[b]));
      pmt_gap_timer #(.W(TW)) u_rec (.clk(CLK_SYS), .srst(SRST),
        .load(hit && rc == PMT_CMD_WRITE), .count(TW'(C_WR_REC)), .done(rec_done[b]));
    end
  endgenerate
  // ----------------------------------------
  // Global spacing timers
  // ----------------------------------------
  assign rc = pmt_cmd_e'(REQ_CMD);
  assign ld_other = take && rc == PMT_CMD_OPEN;
  assign ld_ref = take && rc == PMT_CMD_REFRESH;
  assign ld_rw = take && rc == PMT_CMD_READ;
  assign ld_wr = take && rc == PMT_CMD_WRITE;
  pmt_gap_timer #(.W(TW)) u_other (.clk(CLK_SYS), .srst(SRST), .load(ld_other),
    .count(TW'(C_OPEN_OTHER)), .done(g_open_ok));
  pmt_gap_timer #(.W(TW)) u_ref (.clk(CLK_SYS), .srst(SRST), .load(ld_ref),
    .count(TW'(C_REF_REF)), .done(g_ref_ok));
  pmt_gap_timer #(.W(TW)) u_rw (.clk(CLK_SYS), .srst(SRST), .load(ld_rw),
    .count(TW'(C_RD_WR)), .done(g_rw_ok));
  pmt_gap_timer #(.W(TW)) u_wr (.clk(CLK_SYS), .srst(SRST), .load(ld_wr),
    .count(TW'(C_WR_RD)), .done(g_wr_ok));
  // Shared hold-off: listen wake, control write, self-refresh exit
  always_comb
  begin
    ld_cmd = 1'b0;
    cmd_gap = TW'(C_WAKE);
    if (take && rc == PMT_CMD_CTRL_WR)
    begin
      ld_cmd = 1'b1;
      cmd_gap = TW'(C_CTRL);
    end
    else if (take && rc == PMT_CMD_SR_EXIT)
    begin
      ld_cmd = 1'b1;
      cmd_gap = TW'(C_XSR);
    end
    else if (WANT_LISTEN && !st_r.listen)
      ld_cmd = 1'b1;
  end
  pmt_gap_timer #(.W(TW)) u_cmd (.clk(CLK_SYS), .srst(SRST), .load(ld_cmd),
    .count(cmd_gap), .done(g_cmd_ok));
  // ----------------------------------------
  // Admission check
  // ----------------------------------------
  always_comb
  begin
    ok = g_cmd_ok && st_r.listen && st_r.link_on;
    case (rc)
      PMT_CMD_OPEN: ok = ok && !st_r.in_sr && g_open_ok && same_done[REQ_BANK] && pre_done[REQ_BANK];
      PMT_CMD_CLOSE: ok = ok && !st_r.in_sr && oc_done[REQ_BANK] && rec_done[REQ_BANK];
      PMT_CMD_READ: ok = ok && !st_r.in_sr && g_wr_ok && st_r.open[REQ_BANK];
      PMT_CMD_WRITE: ok = ok && !st_r.in_sr && g_rw_ok && st_r.open[REQ_BANK];
      PMT_CMD_REFRESH: ok = ok && !st_r.in_sr && g_ref_ok && (st_r.open == '0);
      PMT_CMD_CTRL_WR: ok = ok && !st_r.in_sr && (st_r.open == '0)
        && REQ_ARG[15:8] <= 8'(PAGE_READ_DELAY_MAX_TK) && REQ_ARG[7:0] >= 8'(PAGE_WRITE_DELAY_MIN_NS);
      PMT_CMD_SR_ENTER: ok = ok && !st_r.in_sr && (st_r.open == '0);
      PMT_CMD_SR_EXIT: ok = ok && st_r.in_sr;
      PMT_CMD_VERNIER, PMT_CMD_TREG_RD: ok = ok && !st_r.in_sr;
      default: ok = 1'b0;
    endcase
  end
  assign REQ_RDY = ok;
  assign take = REQ_VLD && ok;
  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.div = ~st_r.div;
    st_nxt.cmd_vld = take;
    st_nxt.wd_oe_n = 1'b1;
    if (take)
    begin
      st_nxt.cmd = REQ_CMD;
      st_nxt.bank = REQ_BANK;
      st_nxt.arg = REQ_ARG;
      st_nxt.wd = REQ_WDATA;
      if (rc == PMT_CMD_WRITE)
        st_nxt.wd_oe_n = 1'b0;
      if (rc == PMT_CMD_OPEN)
        st_nxt.open[REQ_BANK] = 1'b1;
      if (rc == PMT_CMD_CLOSE)
        st_nxt.open[REQ_BANK] = 1'b0;
      if (rc == PMT_CMD_SR_ENTER)
        st_nxt.in_sr = 1'b1;
      if (rc == PMT_CMD_SR_EXIT)
        st_nxt.in_sr = 1'b0;
    end
    // Listen drops only between packets; link-on only once listen is low
    if (!take && !st_r.cmd_vld)
      st_nxt.listen = WANT_LISTEN && st_r.link_on;
    if (!st_r.listen && !st_nxt.listen)
      st_nxt.link_on = WANT_LINK_ON;
    if (st_r.listen && !st_nxt.listen)
      st_nxt.link_on = st_r.link_on;
    if (st_r.cmd_vld && st_r.cmd == PMT_CMD_READ)
      st_nxt.rd = LINK.dq;
    // Timing register word stands on dq two cycles after its command
    st_nxt.trd = {st_r.trd[0], st_r.cmd_vld && st_r.cmd == PMT_CMD_TREG_RD};
    if (st_r.trd[1])
      st_nxt.rd = LINK.dq;
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  // ----------------------------------------
  // Link outputs
  // ----------------------------------------
  assign LINK.link_clk = st_r.div;
  assign LINK.listen = st_r.listen;
  assign LINK.link_on = st_r.link_on;
  assign LINK.cmd_vld = st_r.cmd_vld;
  assign LINK.cmd = pmt_cmd_e'(st_r.cmd);
  assign LINK.bank = st_r.bank;
  assign LINK.cmd_arg = st_r.arg;
  assign LINK.dq_ctl_o = st_r.wd;
  assign LINK.dq_ctl_oe_n = st_r.wd_oe_n;
  assign RD_DATA = st_r.rd;
  assign BANKS_CLOSED = (st_r.open == '0);
endmodule
`default_nettype wire

//--- pmt_dev_end.sv
// Device end: tracks active, standby and shutdown, self-refresh with its
// own refresh timer, vernier setting and readable timing registers.
// Assumes controller-side link signals arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module pmt_dev_end
  import pmt_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  pmt_link_if.dev LINK,
  output logic [2:0] MODE,
  output logic SELF_REFRESH,
  output logic REFRESH_PULSE,
  output logic CLOCKS_RUN,
  output logic RX_ENABLE,
  output logic [7:0] VERNIER
);
  typedef struct packed {
    logic [1:0] lsn_s;
    logic [1:0] lon_s;
    logic [1:0] clk_s;
    logic clk_d;
    logic cvld_d;
    pmt_mode_e mode;
    logic sr;
    logic [11:0] osc;
    logic refp;
    logic [7:0] vern_pend;
    logic [7:0] vern;
    logic [3:0] vcnt;
    logic [15:0] dout;
    logic oe_n;
  } pmt_dev_s;
  pmt_dev_s st_r;
  pmt_dev_s st_nxt;
  logic clk_rise;
  logic [15:0] treg;
  // Timing parameter registers, readable by index
  always_comb
  begin
    case (LINK.cmd_arg[2:0])
      3'h0: treg = 16'(OPEN_TO_CLOSE_MIN_NS);
      3'h1: treg = 16'(PRECHARGE_PERIOD_MIN_NS);
      3'h2: treg = 16'(OPEN_TO_OPEN_SAME_BANK_MIN_NS);
      3'h3: treg = 16'(REFRESH_TO_REFRESH_MIN_NS);
      3'h4: treg = 16'(SELF_REFRESH_EXIT_TO_OPEN_MIN_NS);
      3'h5: treg = {8'(WRITE_RECOVERY_FIFO_PART_TK), 8'(WRITE_RECOVERY_INTERNAL_PART_NS)};
      3'h6: treg = {8'(WRITE_TO_READ_FIFO_PART_TK), 8'(WRITE_TO_READ_BALANCE_PART_NS)};
      3'h7: treg = {8'(PAGE_WRITE_DELAY_MIN_NS), 8'(BANK_WRITE_DELAY_MIN_NS)};
      default: treg = 16'h0000;
    endcase
  end
  // Link clock edge; only the second stage feeds logic
  assign clk_rise = st_r.clk_s[1] && !st_r.clk_d;
  // ----------------------------------------
  // Mode and self-refresh sequencing
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.lsn_s = {st_r.lsn_s[0], LINK.listen};
    st_nxt.lon_s = {st_r.lon_s[0], LINK.link_on};
    st_nxt.clk_s = {st_r.clk_s[0], LINK.link_clk};
    st_nxt.clk_d = st_r.clk_s[1];
    st_nxt.cvld_d = LINK.cmd_vld;
    st_nxt.refp = 1'b0;
    st_nxt.oe_n = 1'b1;
    case (st_r.mode)
      PMT_ACTIVE:
        if (!st_r.lsn_s[1])
          st_nxt.mode = PMT_STANDBY;
      PMT_STANDBY:
        if (!st_r.lon_s[1])
          st_nxt.mode = PMT_SHUTDOWN;
        else if (st_r.lsn_s[1])
          st_nxt.mode = PMT_ACTIVE;
      PMT_SHUTDOWN:
        if (st_r.lon_s[1])
          st_nxt.mode = PMT_STANDBY;
      default: st_nxt.mode = PMT_STANDBY;
    endcase
    // Commands act only when active; self-refresh survives nested modes
    if (st_r.mode == PMT_ACTIVE && st_r.cvld_d)
    begin
      case (LINK.cmd)
        PMT_CMD_SR_ENTER: st_nxt.sr = 1'b1;
        PMT_CMD_SR_EXIT: st_nxt.sr = 1'b0;
        PMT_CMD_VERNIER:
        begin
          st_nxt.vern_pend = LINK.cmd_arg[7:0];
          st_nxt.vcnt = 4'(C_VERN - 1); // Receipt edge counts as one
        end
        PMT_CMD_TREG_RD:
        begin
          st_nxt.dout = treg;
          st_nxt.oe_n = 1'b0;
        end
        default: st_nxt.dout = st_r.dout;
      endcase
    end
    // Own oscillator stands in for controller refreshes
    if (st_r.sr)
    begin
      if (st_r.osc == 12'(SELF_REFRESH_PERIOD_CYC - 1))
      begin
        st_nxt.osc = 12'h000;
        st_nxt.refp = 1'b1;
      end
      else
        st_nxt.osc = st_r.osc + 12'h001;
    end
    else
      st_nxt.osc = 12'h000;
    // Vernier applied within its output delay
    if (st_r.vcnt > 4'h1)
      st_nxt.vcnt = st_r.vcnt - 4'h1;
    else if (st_r.vcnt == 4'h1)
    begin
      st_nxt.vcnt = 4'h0;
      st_nxt.vern = st_r.vern_pend;
    end
    if (st_r.mode != PMT_ACTIVE)
      st_nxt.oe_n = 1'b1;
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      st_r <= '0;
      st_r.mode <= PMT_STANDBY;
    end
    else
      st_r <= st_nxt;
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign LINK.dq_dev_o = st_r.dout;
  assign LINK.dq_dev_oe_n = st_r.oe_n;
  assign MODE = st_r.mode;
  assign SELF_REFRESH = st_r.sr;
  assign REFRESH_PULSE = st_r.refp;
  assign CLOCKS_RUN = (st_r.mode != PMT_SHUTDOWN) && clk_rise | (st_r.mode != PMT_SHUTDOWN);
  assign RX_ENABLE = (st_r.mode == PMT_ACTIVE);
  assign VERNIER = st_r.vern;
endmodule
`default_nettype wire

//--- pmt_link_monitor.sv
// Checker on the link between the two ends: command spacing and mode levels.
// Assumes the link signals, system clock and reset arrive as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module pmt_link_monitor
  import pmt_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic listen,
  input wire logic link_on,
  input wire logic cmd_vld,
  input wire pmt_cmd_e cmd,
  input wire logic [2:0] bank,
  input wire logic dq_dev_oe_n
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // ----------------------------------------
  // Cycles since each event
  // ----------------------------------------
  logic [7:0] open_r [8];
  logic [7:0] close_r [8];
  logic [7:0] any_r, ref_r, wr_r, rd_r, ctrl_r, srx_r, lsn_r;
  logic [2:0] wr_bank_r;
  logic in_sr_r, lsn_q_r;
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  function automatic logic [7:0] nxt(input logic hit, input logic [7:0] v);
    return hit ? 8'h01 : inc(v);
  endfunction
  // Saturate, so a reset never looks like a recent command
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      for (int i = 0; i < 8; i++)
      begin
        open_r[i] <= 8'hFF;
        close_r[i] <= 8'hFF;
      end
      {any_r, ref_r, wr_r, rd_r, ctrl_r, srx_r, lsn_r} <= {7{8'hFF}};
      wr_bank_r <= 3'h0;
      in_sr_r <= 1'b0;
      lsn_q_r <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        open_r[i] <= nxt(cmd_vld && cmd == PMT_CMD_OPEN && bank == 3'(i), open_r[i]);
        close_r[i] <= nxt(cmd_vld && cmd == PMT_CMD_CLOSE && bank == 3'(i), close_r[i]);
      end
      any_r <= nxt(cmd_vld && cmd == PMT_CMD_OPEN, any_r);
      ref_r <= nxt(cmd_vld && cmd == PMT_CMD_REFRESH, ref_r);
      wr_r <= nxt(cmd_vld && cmd == PMT_CMD_WRITE, wr_r);
      rd_r <= nxt(cmd_vld && cmd == PMT_CMD_READ, rd_r);
      ctrl_r <= nxt(cmd_vld && cmd == PMT_CMD_CTRL_WR, ctrl_r);
      srx_r <= nxt(cmd_vld && cmd == PMT_CMD_SR_EXIT, srx_r);
      lsn_r <= nxt(listen && !lsn_q_r, lsn_r);
      lsn_q_r <= listen;
      if (cmd_vld && cmd == PMT_CMD_WRITE)
        wr_bank_r <= bank;
      if (cmd_vld && cmd == PMT_CMD_SR_ENTER)
        in_sr_r <= 1'b1;
      else if (cmd_vld && cmd == PMT_CMD_SR_EXIT)
        in_sr_r <= 1'b0;
    end
  end
  // ----------------------------------------
  // Spacing and mode checks
  // ----------------------------------------
  AST_OPEN_TO_CLOSE: assert property (cmd_vld && cmd == PMT_CMD_CLOSE |-> open_r[bank] >= C_OPEN_CLOSE)
    else $error("close too soon after open");
  AST_OPEN_SAME_BANK: assert property (cmd_vld && cmd == PMT_CMD_OPEN |-> open_r[bank] >= C_OPEN_SAME)
    else $error("same bank opened too soon");
  AST_REFRESH_GAP: assert property (cmd_vld && cmd == PMT_CMD_REFRESH |-> ref_r >= C_REF_REF)
    else $error("refresh too soon");
  AST_PRECHARGE_GAP: assert property (cmd_vld && cmd == PMT_CMD_OPEN |-> close_r[bank] >= C_PRE)
    else $error("open inside precharge time");
  AST_OPEN_OTHER_BANK: assert property (cmd_vld && cmd == PMT_CMD_OPEN |-> any_r >= C_OPEN_OTHER)
    else $error("opens too close");
  AST_WRITE_RECOVERY: assert property (cmd_vld && cmd == PMT_CMD_CLOSE && bank == wr_bank_r |-> wr_r >= C_WR_REC)
    else $error("close inside write recovery");
  AST_SELF_REFRESH_EXIT: assert property (cmd_vld && cmd == PMT_CMD_OPEN |-> srx_r >= C_XSR)
    else $error("open too soon after self-refresh exit");
  AST_READ_TO_WRITE: assert property (cmd_vld && cmd == PMT_CMD_WRITE |-> rd_r >= C_RD_WR)
    else $error("write too soon after read");
  AST_WRITE_TO_READ: assert property (cmd_vld && cmd == PMT_CMD_READ |-> wr_r >= C_WR_RD)
    else $error("read too soon after write");
  AST_WAKE_GAP: assert property (cmd_vld |-> lsn_r >= C_WAKE)
    else $error("command too soon after listen");
  AST_CTRL_GAP: assert property (cmd_vld |-> ctrl_r >= C_CTRL)
    else $error("command too soon after control write");
  AST_NO_CMD_IN_SR: assert property (cmd_vld && in_sr_r |-> cmd == PMT_CMD_SR_EXIT)
    else $error("command during self-refresh");
  AST_LINKON_FALL: assert property ($fell(link_on) |-> !listen && !$past(listen))
    else $error("link-on dropped outside standby");
  AST_LISTEN_DROP: assert property (cmd_vld |-> listen)
    else $error("listen low during a command");
  AST_TREG_DRIVE: assert property (cmd_vld && cmd == PMT_CMD_TREG_RD |-> ##[1:5] !dq_dev_oe_n)
    else $error("timing register not driven");
endmodule
`default_nettype wire

//--- dram_power_mode_cmd_timing_bench.sv
// Bench joining controller end and device end over one link.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dram_power_mode_cmd_timing_bench;
  import pmt_pkg::*;
  logic CLK_SYS = 1'b0;
  logic SRST = 1'b1;
  logic REQ_VLD = 1'b0;
  logic [3:0] REQ_CMD = 4'h0;
  logic [2:0] REQ_BANK = 3'h0;
  logic [15:0] REQ_ARG = 16'h0000;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic WANT_LISTEN = 1'b0;
  logic WANT_LINK_ON = 1'b0;
  logic REQ_RDY, BANKS_CLOSED, SELF_REFRESH, REFRESH_PULSE, CLOCKS_RUN, RX_ENABLE;
  logic [15:0] RD_DATA;
  logic [2:0] MODE;
  logic [7:0] VERNIER;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  // 4 ns system clock
  always #2 CLK_SYS = ~CLK_SYS;
  pmt_link_if pmt_link_if_i();
  pmt_ctl_end pmt_ctl_end_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .LINK(pmt_link_if_i), .REQ_VLD(REQ_VLD),
    .REQ_RDY(REQ_RDY), .REQ_CMD(REQ_CMD), .REQ_BANK(REQ_BANK), .REQ_ARG(REQ_ARG), .REQ_WDATA(REQ_WDATA),
    .WANT_LISTEN(WANT_LISTEN), .WANT_LINK_ON(WANT_LINK_ON), .RD_DATA(RD_DATA), .BANKS_CLOSED(BANKS_CLOSED));
  pmt_dev_end pmt_dev_end_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .LINK(pmt_link_if_i), .MODE(MODE),
    .SELF_REFRESH(SELF_REFRESH), .REFRESH_PULSE(REFRESH_PULSE), .CLOCKS_RUN(CLOCKS_RUN),
    .RX_ENABLE(RX_ENABLE), .VERNIER(VERNIER));
  pmt_link_monitor pmt_link_monitor_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .listen(pmt_link_if_i.listen),
    .link_on(pmt_link_if_i.link_on), .cmd_vld(pmt_link_if_i.cmd_vld), .cmd(pmt_link_if_i.cmd),
    .bank(pmt_link_if_i.bank), .dq_dev_oe_n(pmt_link_if_i.dq_dev_oe_n));
  // ----------------------------------------
  // Report, compare and request tasks
  // ----------------------------------------
  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Spacing may stretch a little for pipelining, never shrink
  task automatic gap(input string what, input int least, input int got);
    check(what, 16'h0001, 16'(got >= least && got <= least + 2));
  endtask
  // Request held until the edge that takes it
  task automatic send(input pmt_cmd_e c, input logic [2:0] b, input logic [15:0] a, output int t);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    REQ_VLD <= 1'b1;
    REQ_CMD <= c;
    REQ_BANK <= b;
    REQ_ARG <= a;
    REQ_WDATA <= ~a;
    @(negedge CLK_SYS);
    while (REQ_RDY !== 1'b1 && n < 200)
    begin
      @(negedge CLK_SYS);
      n++;
    end
    @(posedge CLK_SYS);
    t = cyc;
    REQ_VLD <= 1'b0;
    check("request taken", 16'h0001, 16'(n < 200));
  endtask
  task automatic wait_mode(input pmt_mode_e m);
    repeat (12)
      if (MODE !== m)
        @(negedge CLK_SYS);
    check("mode", 16'(m), 16'(MODE));
  endtask
  task automatic wait_bit(input string what, ref logic s, input logic v);
    repeat (12)
      if (s !== v)
        @(negedge CLK_SYS);
    check(what, 16'(v), 16'(s));
  endtask
  // Cycle count and hang limit
  always @(posedge CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (cyc == 12000)
    begin
      num_errors++;
      final_report();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int t0, t1, t2, t3, k;
    repeat (4) @(posedge CLK_SYS);
    SRST <= 1'b0;
    @(negedge CLK_SYS);
    check("mode", 16'(PMT_STANDBY), 16'(MODE));
    check("self refresh", 16'h0000, 16'(SELF_REFRESH));
    check("vernier", 16'h0000, 16'(VERNIER));
    check("req_rdy", 16'h0000, 16'(REQ_RDY));
    @(posedge CLK_SYS);
    WANT_LINK_ON <= 1'b1;
    WANT_LISTEN <= 1'b1;
    wait_mode(PMT_ACTIVE);
    wait_bit("rx enable", RX_ENABLE, 1'b1);
    // Row spacing across and within banks
    send(PMT_CMD_OPEN, 3'h0, 16'h0000, t0);
    send(PMT_CMD_OPEN, 3'h1, 16'h0000, t1);
    gap("open other", C_OPEN_OTHER, t1 - t0);
    check("banks closed", 16'h0000, 16'(BANKS_CLOSED));
    send(PMT_CMD_CLOSE, 3'h0, 16'h0000, t2);
    gap("open close", C_OPEN_CLOSE, t2 - t0);
    send(PMT_CMD_OPEN, 3'h0, 16'h0000, t3);
    gap("open same", C_OPEN_SAME, t3 - t0);
    gap("precharge", C_PRE, t3 - t2);
    // Write, read, write, close on one bank
    send(PMT_CMD_WRITE, 3'h1, 16'h3C5A, t0);
    send(PMT_CMD_READ, 3'h1, 16'h0000, t1);
    gap("write read", C_WR_RD, t1 - t0);
    send(PMT_CMD_WRITE, 3'h1, 16'hA5C3, t2);
    gap("read write", C_RD_WR, t2 - t1);
    send(PMT_CMD_CLOSE, 3'h1, 16'h0000, t3);
    gap("write recovery", C_WR_REC, t3 - t2);
    send(PMT_CMD_CLOSE, 3'h0, 16'h0000, t0);
    wait_bit("banks closed", BANKS_CLOSED, 1'b1);
    send(PMT_CMD_REFRESH, 3'h0, 16'h0000, t0);
    send(PMT_CMD_REFRESH, 3'h0, 16'h0000, t1);
    gap("refresh", C_REF_REF, t1 - t0);
    // Control word with too short a write delay is held off
    @(posedge CLK_SYS);
    REQ_VLD <= 1'b1;
    REQ_CMD <= PMT_CMD_CTRL_WR;
    REQ_ARG <= 16'h2010;
    @(negedge CLK_SYS);
    check("req_rdy", 16'h0000, 16'(REQ_RDY));
    @(posedge CLK_SYS);
    REQ_VLD <= 1'b0;
    send(PMT_CMD_CTRL_WR, 3'h0, 16'h2011, t0);
    send(PMT_CMD_VERNIER, 3'h0, 16'h00A5, t1);
    gap("control write", C_CTRL, t1 - t0);
    k = 0;
    while (VERNIER !== 8'hA5 && k < C_VERN + 2)
    begin
      @(negedge CLK_SYS);
      k++;
    end
    check("vernier", 16'h00A5, 16'(VERNIER));
    for (k = 0; k < TREG_COUNT; k++)
      send(PMT_CMD_TREG_RD, 3'h0, 16'(k), t0);
    repeat (4) @(negedge CLK_SYS);
    check("timing register", {8'(PAGE_WRITE_DELAY_MIN_NS), 8'(BANK_WRITE_DELAY_MIN_NS)}, RD_DATA);
    // Self-refresh refuses row traffic, then nests standby and shutdown
    send(PMT_CMD_SR_ENTER, 3'h0, 16'h0000, t0);
    wait_bit("self refresh", SELF_REFRESH, 1'b1);
    @(posedge CLK_SYS);
    REQ_VLD <= 1'b1;
    REQ_CMD <= PMT_CMD_OPEN;
    REQ_BANK <= 3'h2;
    repeat (5)
    begin
      @(negedge CLK_SYS);
      check("req_rdy", 16'h0000, 16'(REQ_RDY));
    end
    @(posedge CLK_SYS);
    REQ_VLD <= 1'b0;
    WANT_LISTEN <= 1'b0;
    wait_mode(PMT_STANDBY);
    check("self refresh", 16'h0001, 16'(SELF_REFRESH));
    @(posedge CLK_SYS);
    WANT_LINK_ON <= 1'b0;
    wait_mode(PMT_SHUTDOWN);
    check("clocks run", 16'h0000, 16'(CLOCKS_RUN));
    check("rx enable", 16'h0000, 16'(RX_ENABLE));
    k = 0;
    repeat (2 * SELF_REFRESH_PERIOD_CYC)
    begin
      @(negedge CLK_SYS);
      if (REFRESH_PULSE === 1'b1)
        k++;
    end
    check("refresh pulses", 16'h0002, 16'(k));
    @(posedge CLK_SYS);
    WANT_LINK_ON <= 1'b1;
    wait_mode(PMT_STANDBY);
    @(posedge CLK_SYS);
    WANT_LISTEN <= 1'b1;
    wait_mode(PMT_ACTIVE);
    send(PMT_CMD_SR_EXIT, 3'h0, 16'h0000, t0);
    wait_bit("self refresh", SELF_REFRESH, 1'b0);
    send(PMT_CMD_OPEN, 3'h3, 16'h0000, t1);
    gap("self refresh exit", C_XSR, t1 - t0);
    final_report();
  end
endmodule
`default_nettype wire
